// >>> hdl/kpi_keypad_interrupt_unit.sv
// Overview of operation
// - Interrupt enable bit 1 gates whether a set flag raises a request.
// - Mode bit 0 selects edge-only or edge-plus-level detection for all pins.
// - Per-pin enable bits 5,4,2:0 admit each pin as a source.
// - Polarity bit 0 means falling/low, 1 means rising/high per pin.
// - Falling edge is high sample then low sample on next clock.
// - Rising edge is low sample then high sample on next clock.
// - Edge-only mode: valid edge on enabled pin sets sticky flag.
// - Flag set with interrupt enable raises the processor request.
// - Edge-only mode: writing 1 to acknowledge clears the flag.
// - Edge-plus-level mode: edge or active level sets the flag.
// - Edge-plus-level mode: acknowledge clears only when all enabled pins inactive.
// - Enabling pins never turns on pull devices; pulls are separate.
// - Enabled pin with interrupt enabled produces a wake-up event.
// - Flag at bit 3 is read-only; writes leave it alone.
// - Acknowledge bit 2 always reads as zero.
`timescale 1ns/1ps
`default_nettype none
`include "kpi_defines.svh"

module kpi_keypad_interrupt_unit #(
    parameter int PIN_W = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [`KPI_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [PIN_W-1:0] keypad_input_pin_in,
    output logic irq_request_out,
    output logic wake_out,
    output logic evt_irq_out
);

    // Detection is written for the eight-bit port layout only
    if (PIN_W != 8) begin : g_check_pin_w
        $error("PIN_W must be 8");
    end
    // Event bits must fit the byte-wide read path
    if (`KPI_EVT_W > 8) begin : g_check_evt_w
        $error("KPI_EVT_W must not exceed 8");
    end

    kpi_pkg::kpi_bus_s bus;
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    logic [7:0] pin_enable_n_reg;
    logic [7:0] pin_polarity_n_reg;
    logic irq_request_enable_reg;
    logic edge_level_mode_reg;
    logic detect_flag_reg;
    logic [PIN_W-1:0] sample_reg;
    logic [PIN_W-1:0] armed_reg;
    logic [`KPI_EVT_W-1:0] evt_status_reg;
    logic [`KPI_EVT_W-1:0] evt_enable_reg;
    logic [7:0] rdata_reg;
    logic wake_reg;
    kpi_pkg::kpi_state_e state_reg;

    logic [7:0] pin_mask;
    logic [PIN_W-1:0] active_now;
    logic [PIN_W-1:0] active_prev;
    logic edge_hit;
    logic level_hit;
    logic set_flag;
    logic ack_write;
    logic clear_blocked;
    logic detect_live;
    logic [PIN_W-1:0] pin_edge;
    logic [PIN_W-1:0] pin_level;
    logic [7:0] rdata_next;
    logic [7:0] status_byte;
    logic wr_status;
    logic wr_enable;
    logic wr_polarity;
    logic wr_evt_clear;
    logic wr_evt_enable;
    logic [`KPI_EVT_W-1:0] evt_clear;

    // Active level per pin after polarity; only real pin positions count
    function automatic logic [PIN_W-1:0] asserted(input logic [PIN_W-1:0] v, input logic [7:0] pol);
        asserted = (v ~^ pol) & `KPI_PIN_MASK;
    endfunction

    function automatic logic wr_hit(input kpi_pkg::kpi_bus_s b, input logic [`KPI_ADDR_W-1:0] a);
        wr_hit = b.wr && (b.addr == a);
    endfunction

    function automatic logic [7:0] pad_evt(input logic [`KPI_EVT_W-1:0] v);
        pad_evt = {{(8-`KPI_EVT_W){1'b0}}, v};
    endfunction

    assign pin_mask = pin_enable_n_reg & `KPI_PIN_MASK;
    assign active_now = asserted(keypad_input_pin_in, pin_polarity_n_reg) & pin_mask;
    assign active_prev = asserted(sample_reg, pin_polarity_n_reg) & pin_mask;

    // Per-pin terms kept apart so a stuck pin shows on its own bit
    always_comb begin
        pin_edge = '0;
        pin_level = '0;
        for (int i = 0; i < PIN_W; i++) begin
            // Edge only after an inactive sample was seen while armed
            pin_edge[i] = active_now[i] && !active_prev[i] && armed_reg[i];
            pin_level[i] = edge_level_mode_reg && active_now[i];
        end
    end

    // Nothing counts until some pin has been enabled for a cycle
    assign detect_live = (state_reg == kpi_pkg::KPI_RUN);
    assign edge_hit = |pin_edge;
    assign level_hit = |pin_level;
    assign set_flag = (edge_hit || level_hit) && detect_live;
    // Any enabled pin still active holds the flag in level mode
    assign clear_blocked = edge_level_mode_reg && (|active_now);

    assign wr_status = wr_hit(bus, `KPI_OFS_STATUS_CONTROL);
    assign wr_enable = wr_hit(bus, `KPI_OFS_ENABLE_MASK);
    assign wr_polarity = wr_hit(bus, `KPI_OFS_POLARITY_SELECT);
    assign wr_evt_clear = wr_hit(bus, `KPI_OFS_EVT_CLEAR);
    assign wr_evt_enable = wr_hit(bus, `KPI_OFS_EVT_ENABLE);
    assign ack_write = wr_status && bus.wdata[`KPI_BIT_ACK];

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sample_reg <= '0;
        end else begin
            sample_reg <= keypad_input_pin_in;
        end
    end

    // Arming blocks a false edge from a pin just enabled while already active
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            armed_reg <= '0;
        end else begin
            armed_reg <= ~active_now & pin_mask;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= kpi_pkg::KPI_IDLE;
        end else begin
            case (state_reg)
                kpi_pkg::KPI_IDLE: begin
                    if (|pin_mask) begin
                        state_reg <= kpi_pkg::KPI_RUN;
                    end
                end
                kpi_pkg::KPI_RUN: begin
                    if (~|pin_mask) begin
                        state_reg <= kpi_pkg::KPI_IDLE;
                    end
                end
                default: begin
                    state_reg <= kpi_pkg::KPI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_request_enable_reg <= 1'b0;
        end else if (wr_status) begin
            irq_request_enable_reg <= bus.wdata[`KPI_BIT_IRQ_EN];
        end
    end

    // Mode is rewritten by every control write, like the enable bit
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            edge_level_mode_reg <= 1'b0;
        end else if (wr_status) begin
            edge_level_mode_reg <= bus.wdata[`KPI_BIT_MODE];
        end
    end

    // Unbonded positions are forced low so they read back as zero
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_enable_n_reg <= `KPI_RESET_BYTE;
        end else if (wr_enable) begin
            pin_enable_n_reg <= bus.wdata & `KPI_PIN_MASK;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_polarity_n_reg <= `KPI_RESET_BYTE;
        end else if (wr_polarity) begin
            pin_polarity_n_reg <= bus.wdata & `KPI_PIN_MASK;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            evt_enable_reg <= '0;
        end else if (wr_evt_enable) begin
            evt_enable_reg <= bus.wdata[`KPI_EVT_W-1:0];
        end
    end

    // Set wins over acknowledge; in level mode an active pin also blocks the clear
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            detect_flag_reg <= 1'b0;
        end else if (set_flag && state_reg == kpi_pkg::KPI_RUN) begin
            detect_flag_reg <= 1'b1;
        end else if (ack_write && !(edge_level_mode_reg && (|active_now))) begin
            detect_flag_reg <= 1'b0;
        end
    end

    // Wake high the cycle after each set_flag cycle while requests are enabled, so an active level in level mode holds it
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= set_flag && irq_request_enable_reg && (state_reg == kpi_pkg::KPI_RUN);
        end
    end

    logic [`KPI_EVT_W-1:0] evt_set;
    assign evt_set = {wake_reg, set_flag};
    assign evt_clear = wr_evt_clear ? bus.wdata[`KPI_EVT_W-1:0] : '0;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            evt_status_reg <= '0;
        end else begin
            // Set wins over a clear in the same cycle
            evt_status_reg <= (evt_status_reg & ~evt_clear) | evt_set;
        end
    end

    // Acknowledge bit always reads zero
    assign status_byte = {4'h0, detect_flag_reg, 1'b0, irq_request_enable_reg, edge_level_mode_reg};

    // Idle cycles return zero so a stale byte never passes for an answer
    always_comb begin
        rdata_next = `KPI_RESET_BYTE;
        if (bus.rd) begin
            case (bus.addr)
                `KPI_OFS_STATUS_CONTROL: begin
                    rdata_next = status_byte;
                end
                `KPI_OFS_ENABLE_MASK: begin
                    rdata_next = pin_enable_n_reg;
                end
                `KPI_OFS_POLARITY_SELECT: begin
                    rdata_next = pin_polarity_n_reg;
                end
                `KPI_OFS_EVT_STATUS: begin
                    rdata_next = pad_evt(evt_status_reg);
                end
                `KPI_OFS_EVT_ENABLE: begin
                    rdata_next = pad_evt(evt_enable_reg);
                end
                default: begin
                    rdata_next = `KPI_RESET_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_reg <= `KPI_RESET_BYTE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_out = rdata_reg;
    assign irq_request_out = detect_flag_reg && irq_request_enable_reg;
    assign wake_out = wake_reg;
    assign evt_irq_out = |(evt_status_reg & evt_enable_reg);

endmodule

`default_nettype wire

// >>> hdl/kpi_defines.svh
`ifndef KPI_DEFINES_SVH
`define KPI_DEFINES_SVH

`define KPI_ADDR_W 4
`define KPI_OFS_STATUS_CONTROL 4'h0
`define KPI_OFS_ENABLE_MASK 4'h1
`define KPI_OFS_POLARITY_SELECT 4'h2
`define KPI_OFS_EVT_STATUS 4'h3
`define KPI_OFS_EVT_CLEAR 4'h4
`define KPI_OFS_EVT_ENABLE 4'h5

`define KPI_BIT_MODE 0
`define KPI_BIT_IRQ_EN 1
`define KPI_BIT_ACK 2
`define KPI_BIT_FLAG 3

`define KPI_PIN_MASK 8'h37
`define KPI_RESET_BYTE 8'h00

`define KPI_EVT_W 2
`define KPI_EVT_DETECT 0
`define KPI_EVT_WAKE 1

`endif

// >>> hdl/kpi_pkg.sv
`default_nettype none
`include "kpi_defines.svh"

package kpi_pkg;

    typedef struct packed {
        logic [`KPI_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } kpi_bus_s;

    typedef enum logic [1:0] {
        KPI_IDLE = 2'b00,
        KPI_RUN = 2'b01
    } kpi_state_e;

endpackage

`default_nettype wire

// >>> bench/kpi_unit_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "kpi_defines.svh"
module kpi_unit_props #(
    parameter int PIN_W = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [`KPI_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [PIN_W-1:0] keypad_input_pin_in,
    input wire logic irq_request_out,
    input wire logic wake_out,
    input wire logic evt_irq_out
);
    logic [1:0] ctl_reg;
    logic [2:0] quiet_reg;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_reg <= 2'h0;
        end else if (wr_in && addr_in == 4'h0) begin
            ctl_reg <= wdata_in[1:0];
        end
    end
    // Pins and bus quiet long enough that no edge can still be in flight
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            quiet_reg <= 3'h0;
        end else if (wr_in || !$stable(keypad_input_pin_in & PIN_W'(`KPI_PIN_MASK))) begin
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_ctrl_read;
        $past(rd_in) && $past(addr_in) == 4'h0;
    endsequence
    sequence s_edge_ack;
        wr_in && addr_in == 4'h0 && wdata_in[2:0] == 3'b110 && !ctl_reg[0] && quiet_reg == 3'h7;
    endsequence
    a_ack_reads_zero: assert property (s_ctrl_read |-> rdata_out[7:4] == 4'h0 && !rdata_out[2])
        else $error("ack or upper bits read nonzero");
    a_ctrl_readback: assert property (s_ctrl_read |-> rdata_out[1:0] == $past(ctl_reg))
        else $error("mode or enable readback wrong");
    a_flag_vs_irq: assert property (s_ctrl_read ##0 $past(ctl_reg[1]) |-> rdata_out[3] == $past(irq_request_out))
        else $error("flag and request disagree");
    a_irq_gated_en: assert property (irq_request_out |-> ctl_reg[1])
        else $error("request while disabled");
    a_irq_sticky: assert property (irq_request_out && !(wr_in && addr_in == 4'h0) |=> irq_request_out)
        else $error("flag dropped without ack");
    a_edge_ack_clear: assert property (s_edge_ack |=> !irq_request_out)
        else $error("ack did not clear flag");
    a_wake_needs_en: assert property (wake_out |-> ctl_reg[1] || $past(ctl_reg[1]))
        else $error("wake without irq enable");
    a_evt_mask_off: assert property (wr_in && addr_in == 4'h5 && wdata_in == 8'h00 |=> !evt_irq_out)
        else $error("event irq not masked");
    a_wake_on_flag: assert property ($rose(irq_request_out) && $past(ctl_reg[1]) |-> wake_out)
        else $error("no wake on fresh detection");
endmodule
bind kpi_keypad_interrupt_unit kpi_unit_props #(.PIN_W(PIN_W)) u_props (.clk_in(clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .keypad_input_pin_in(keypad_input_pin_in), .irq_request_out(irq_request_out), .wake_out(wake_out),
    .evt_irq_out(evt_irq_out));
`default_nettype wire

// >>> bench/kpi_keypad_model.sv
`timescale 1ns/1ps
`default_nettype none
module kpi_keypad_model (
    input wire logic clk_in,
    input wire logic [7:0] press_in,
    input wire logic [7:0] pol_in,
    output logic [7:0] pin_out
);
    logic [2:0] spare_reg = 3'h0;
    initial pin_out = 8'hff;
    // Unbonded pins wander so they cannot pass for idle
    always @(posedge clk_in) begin
        spare_reg <= spare_reg + 3'h1;
        pin_out <= {spare_reg[2:1], ~(press_in[5:4] ^ pol_in[5:4]), spare_reg[0], ~(press_in[2:0] ^ pol_in[2:0])};
    end
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    kpi_pkg::kpi_bus_s bus = '0;
    logic [7:0] press = 8'h00, pol = 8'h00, pins, rdata_out, b, d;
    logic irq_request_out, evt_irq_out, rd_d = 1'b0;
    logic [9:0] note_q[$], e;
    int n_mismatch = 0, num_checks = 0, sel[5] = '{0, 1, 2, 4, 5};
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    kpi_keypad_model keys (.clk_in(clk_in), .press_in(press), .pol_in(pol), .pin_out(pins));
    kpi_keypad_interrupt_unit dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(bus.addr), .wdata_in(bus.wdata),
        .wr_in(bus.wr), .rd_in(bus.rd), .rdata_out(rdata_out), .keypad_input_pin_in(pins),
        .irq_request_out(irq_request_out), .wake_out(), .evt_irq_out(evt_irq_out));
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_in);
        bus <= '0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [9:0] x);
        note_q.push_back(x);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_in);
        bus <= '0;
        @(posedge clk_in);
    endtask
    // Note holds {event irq, request, read data}
    always @(posedge clk_in) begin
        rd_d <= bus.rd;
        if (rd_d) begin
            e = note_q.pop_front();
            num_checks++;
            if ({evt_irq_out, irq_request_out, rdata_out} !== e) begin
                n_mismatch++;
                $display("MISMATCH read expected %h seen %h", e, {evt_irq_out, irq_request_out, rdata_out});
            end
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h49865760));
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        wr(4'h6, 8'hff);
        for (int a = 0; a < 7; a++) rd(4'(a), 10'h000);
        $display("test reset values done");
        d = 8'($urandom());
        pol <= ~d;
        wr(4'h2, ~d);
        wr(4'h1, d);
        rd(4'h1, {2'b00, d & 8'h37});
        rd(4'h2, {2'b00, ~d & 8'h37});
        wr(4'h0, 8'hff);
        rd(4'h0, 10'h003);
        wr(4'h0, 8'h00);
        $display("test register access done");
        for (int k = 0; k < 10; k++) begin
            b = 8'h01 << sel[k / 2];
            pol <= (k % 2) ? b : 8'h00;
            wr(4'h0, 8'h00);
            wr(4'h2, (k % 2) ? b : 8'h00);
            wr(4'h1, b);
            wr(4'h0, 8'h04);
            wr(4'h0, 8'h02);
            press <= 8'h37 & ~b;
            repeat (6) @(posedge clk_in);
            rd(4'h0, 10'h002);
            press <= 8'h37;
            repeat (6) @(posedge clk_in);
            rd(4'h0, 10'h10a);
            press <= 8'h00;
            repeat (10) @(posedge clk_in);
            wr(4'h0, 8'h06);
            rd(4'h0, 10'h002);
        end
        $display("test pin edges done");
        pol <= 8'h00;
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h01);
        wr(4'h0, 8'h04);
        wr(4'h0, 8'h03);
        press <= 8'h01;
        repeat (6) @(posedge clk_in);
        wr(4'h0, 8'h07);
        rd(4'h0, 10'h10b);
        press <= 8'h02;
        repeat (6) @(posedge clk_in);
        wr(4'h0, 8'h01);
        rd(4'h0, 10'h009);
        wr(4'h0, 8'h07);
        rd(4'h0, 10'h003);
        $display("test level mode done");
        wr(4'h5, 8'h03);
        rd(4'h3, 10'h203);
        wr(4'h5, 8'h00);
        rd(4'h5, 10'h000);
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h03);
        rd(4'h3, 10'h000);
        $display("test event register done");
        results();
    end
endmodule
`default_nettype wire
